// ---- design/ita_defs.svh ----
`ifndef ITA_DEFS_SVH
`define ITA_DEFS_SVH

// Register offsets inside the indirect-access bank
`define ITA_OFF_CMD 4'h0
`define ITA_OFF_TOP 4'h2
`define ITA_OFF_W2 4'h4
`define ITA_OFF_W3 4'h6
`define ITA_OFF_W0 4'h8
`define ITA_OFF_W1 4'ha
`define ITA_OFF_BANK_SEL 4'he
// Bank numbers
`define ITA_BANK_INDIRECT 8'h2a
`define ITA_BANK_RESERVED 8'h2b
// Command field positions
`define ITA_CMD_DIR_BIT 12
`define ITA_CMD_SEL_HI 11
`define ITA_CMD_SEL_LO 10
`define ITA_CMD_ADDR_HI 9
`define ITA_CMD_ADDR_LO 0
`define ITA_CMD_RW_MASK 16'h1fff
// Status bit in the top data register
`define ITA_TOP_BUSY_BIT 7
// Reset values
`define ITA_RST_CMD 16'h0000
`define ITA_RST_WORD 16'h0000
`define ITA_RST_BANK 8'h00
// Load value for wait_cnt on every control write; reads end on the table answer, not after a fixed count
`define ITA_READ_LAT 4'h4

`endif

// ---- design/ita_pkg.sv ----
package ita_pkg;
    typedef enum logic [1:0] {
        ITA_TBL_STATIC = 2'b00,
        ITA_TBL_VLAN = 2'b01,
        ITA_TBL_DYNAMIC = 2'b10,
        ITA_TBL_COUNTER = 2'b11
    } ita_table_t;

    typedef enum logic [1:0] {
        ITA_ST_IDLE = 2'b00,
        ITA_ST_ISSUE = 2'b01,
        ITA_ST_WAIT = 2'b10
    } ita_state_t;

    // Request toward the table engine
    typedef struct packed {
        logic valid;
        logic is_read;
        ita_table_t table_sel;
        logic [9:0] addr;
        logic [66:0] data;
    } ita_req_t;

    // Answer from the table engine
    typedef struct packed {
        logic valid;
        logic [66:0] data;
    } ita_rsp_t;

    // Whole register and sequencer state
    typedef struct packed {
        ita_state_t state;
        logic [7:0] bank;
        logic [15:0] cmd;
        logic [66:0] data;
        logic busy;
        logic [3:0] wait_cnt;
        logic [15:0] rdata;
        ita_req_t req;
    } ita_state_all_t;
endpackage : ita_pkg

// ---- design/ita_indirect_table_access.sv ----
// Added by the designer: the strobed register port.
`include "ita_defs.svh"

// Functional notes
// - Control write launches one table operation
// - Bit 12 one reads, zero writes
// - Bits 11:10 choose the target table
// - Bits 9:0 give entry address
// - Bit 7 busy during dynamic/counter reads
// - Top register bits 2:0 hold data 66:64
// - Word two holds data 47:32
// - Word three holds data 63:48
// - Word zero holds data 15:0
// - Word one holds data 31:16
// - Bank select works in reserved bank
module ita_indirect_table_access (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output ita_pkg::ita_req_t tbl_req_o,
    input wire ita_pkg::ita_rsp_t tbl_rsp_i
);
    ita_pkg::ita_state_all_t st;
    ita_pkg::ita_state_all_t next_st;

    logic in_ind;
    logic in_bsel;
    logic wr_cmd;
    logic slow_read;

    // Address decode
    always_comb begin
        in_ind = (st.bank == `ITA_BANK_INDIRECT);
        in_bsel = (reg_addr_i == `ITA_OFF_BANK_SEL);
        wr_cmd = reg_wr_i && in_ind && (reg_addr_i == `ITA_OFF_CMD);
        slow_read = reg_wdata_i[`ITA_CMD_DIR_BIT] && reg_wdata_i[`ITA_CMD_SEL_HI];
    end

    // Register file and sequencer next state
    always_comb begin
        next_st = st;
        next_st.req.valid = 1'b0;
        // Bank select answers in every bank, the reserved one included
        if (reg_wr_i && in_bsel) begin
            next_st.bank = reg_wdata_i[7:0];
        end
        if (reg_wr_i && in_ind) begin
            unique case (reg_addr_i)
                `ITA_OFF_W2: next_st.data[47:32] = reg_wdata_i;
                `ITA_OFF_W3: next_st.data[63:48] = reg_wdata_i;
                `ITA_OFF_W0: next_st.data[15:0] = reg_wdata_i;
                `ITA_OFF_W1: next_st.data[31:16] = reg_wdata_i;
                default: begin
                end
            endcase
        end
        // Launch on every control write
        if (wr_cmd) begin
            next_st.cmd = reg_wdata_i & `ITA_CMD_RW_MASK;
            next_st.req.valid = 1'b1;
            next_st.req.is_read = reg_wdata_i[`ITA_CMD_DIR_BIT];
            next_st.req.table_sel = ita_pkg::ita_table_t'(reg_wdata_i[`ITA_CMD_SEL_HI:`ITA_CMD_SEL_LO]);
            next_st.req.addr = reg_wdata_i[`ITA_CMD_ADDR_HI:`ITA_CMD_ADDR_LO];
            next_st.req.data = st.data;
            next_st.busy = slow_read;
            next_st.wait_cnt = `ITA_READ_LAT;
            next_st.state = reg_wdata_i[`ITA_CMD_DIR_BIT] ? ita_pkg::ITA_ST_WAIT : ita_pkg::ITA_ST_IDLE;
        end else begin
            unique case (st.state)
                ita_pkg::ITA_ST_IDLE: begin
                end
                ita_pkg::ITA_ST_ISSUE: next_st.state = ita_pkg::ITA_ST_WAIT;
                ita_pkg::ITA_ST_WAIT: begin
                    // Table answer loads the data word; busy falls with it
                    if (tbl_rsp_i.valid) begin
                        next_st.data = tbl_rsp_i.data;
                        next_st.busy = 1'b0;
                        next_st.state = ita_pkg::ITA_ST_IDLE;
                    end
                end
                default: next_st.state = ita_pkg::ITA_ST_IDLE;
            endcase
        end
        // Read data, valid only the cycle after the strobe
        next_st.rdata = 16'h0000;
        if (reg_rd_i) begin
            if (in_bsel) begin
                next_st.rdata = {8'h00, st.bank};
            end else if (in_ind) begin
                unique case (reg_addr_i)
                    `ITA_OFF_CMD: next_st.rdata = st.cmd;
                    `ITA_OFF_TOP: next_st.rdata = {8'h00, st.busy, 4'h0, st.data[66:64]};
                    `ITA_OFF_W2: next_st.rdata = st.data[47:32];
                    `ITA_OFF_W3: next_st.rdata = st.data[63:48];
                    `ITA_OFF_W0: next_st.rdata = st.data[15:0];
                    `ITA_OFF_W1: next_st.rdata = st.data[31:16];
                    default: next_st.rdata = 16'h0000;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign tbl_req_o = st.req;

    // Checks
    sequence cmd_write_s;
        reg_wr_i && in_ind && reg_addr_i == `ITA_OFF_CMD;
    endsequence

    launch_one_op_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> tbl_req_o.valid) else $error("control write did not launch");
    no_spurious_op_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        tbl_req_o.valid |-> $past(wr_cmd)) else $error("launch without control write");
    dir_from_bit_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> tbl_req_o.is_read == $past(reg_wdata_i[12])) else $error("wrong direction");
    table_select_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> tbl_req_o.table_sel == $past(reg_wdata_i[11:10])) else $error("wrong table");
    entry_addr_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> tbl_req_o.addr == $past(reg_wdata_i[9:0])) else $error("wrong address");
    busy_set_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s ##0 (reg_wdata_i[12] && reg_wdata_i[11]) |=> st.busy) else $error("busy not set");
    busy_clear_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.busy && tbl_rsp_i.valid && !wr_cmd |=> !st.busy) else $error("busy not cleared");
    top_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_rd_i && in_ind && !in_bsel && reg_addr_i == `ITA_OFF_TOP |=>
        reg_rdata_o[2:0] == $past(st.data[66:64]) && reg_rdata_o[7] == $past(st.busy)) else $error("bad top read");
    word_two_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && in_ind && reg_addr_i == `ITA_OFF_W2 |=> st.data[47:32] == $past(reg_wdata_i))
        else $error("word two not stored");
    word_three_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && in_ind && reg_addr_i == `ITA_OFF_W3 |=> st.data[63:48] == $past(reg_wdata_i))
        else $error("word three not stored");
    word_zero_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && in_ind && reg_addr_i == `ITA_OFF_W0 |=> st.data[15:0] == $past(reg_wdata_i))
        else $error("word zero not stored");
    word_one_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && in_ind && reg_addr_i == `ITA_OFF_W1 |=> st.data[31:16] == $past(reg_wdata_i))
        else $error("word one not stored");
    bank_any_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == `ITA_OFF_BANK_SEL |=> st.bank == $past(reg_wdata_i[7:0]))
        else $error("bank select ignored");

    // Further checks, built from the bus steps below

    // Control register read in the indirect bank
    sequence cmd_read_s;
        reg_rd_i && in_ind && !in_bsel && reg_addr_i == `ITA_OFF_CMD;
    endsequence
    // Control write that asks for a table read
    sequence read_cmd_s;
        cmd_write_s ##0 reg_wdata_i[`ITA_CMD_DIR_BIT];
    endsequence
    // Control write that asks for a table write
    sequence write_cmd_s;
        cmd_write_s ##0 !reg_wdata_i[`ITA_CMD_DIR_BIT];
    endsequence
    // Table answer taken while a read waits
    sequence answer_taken_s;
        st.state == ita_pkg::ITA_ST_WAIT && tbl_rsp_i.valid && !wr_cmd;
    endsequence
    // Top register read in the indirect bank
    sequence top_read_s;
        reg_rd_i && in_ind && reg_addr_i == `ITA_OFF_TOP;
    endsequence
    // Write aimed at the read-only top register, no answer beside it
    sequence top_write_s;
        reg_wr_i && reg_addr_i == `ITA_OFF_TOP && !(st.state == ita_pkg::ITA_ST_WAIT && tbl_rsp_i.valid);
    endsequence
    // Write outside the indirect bank, no answer beside it
    sequence foreign_write_s;
        reg_wr_i && !in_ind && !in_bsel && !(st.state == ita_pkg::ITA_ST_WAIT && tbl_rsp_i.valid);
    endsequence
    // Read outside the indirect bank
    sequence foreign_read_s;
        reg_rd_i && !in_ind && !in_bsel;
    endsequence
    // Word two read
    sequence w2_read_s;
        reg_rd_i && in_ind && reg_addr_i == `ITA_OFF_W2;
    endsequence
    // Word three read
    sequence w3_read_s;
        reg_rd_i && in_ind && reg_addr_i == `ITA_OFF_W3;
    endsequence
    // Word zero read
    sequence w0_read_s;
        reg_rd_i && in_ind && reg_addr_i == `ITA_OFF_W0;
    endsequence
    // Word one read
    sequence w1_read_s;
        reg_rd_i && in_ind && reg_addr_i == `ITA_OFF_W1;
    endsequence

    // Launch strobe lasts one cycle
    req_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        tbl_req_o.valid && !wr_cmd |=> !tbl_req_o.valid)
        else $error("launch strobe too long");

    // Launch carries the data word as loaded
    req_data_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> tbl_req_o.data == $past(st.data))
        else $error("launch data differs from words");

    // Control offset in another bank launches nothing
    foreign_cmd_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && !in_ind && reg_addr_i == `ITA_OFF_CMD |=> !tbl_req_o.valid)
        else $error("launch from wrong bank");

    // Table read waits for its answer
    read_wait_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        read_cmd_s |=> st.state == ita_pkg::ITA_ST_WAIT)
        else $error("read did not wait");

    // Table write needs no answer
    write_idle_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        write_cmd_s |=> st.state == ita_pkg::ITA_ST_IDLE)
        else $error("write left sequencer busy");

    // Waiting holds until an answer or a new command
    wait_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.state == ita_pkg::ITA_ST_WAIT && !tbl_rsp_i.valid && !wr_cmd |=> st.state == ita_pkg::ITA_ST_WAIT)
        else $error("wait dropped early");

    // Only idle and wait are ever reached
    state_legal_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.state == ita_pkg::ITA_ST_IDLE || st.state == ita_pkg::ITA_ST_WAIT)
        else $error("sequencer in unused state");

    // Control value kept, reserved bits dropped
    cmd_store_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> st.cmd == ($past(reg_wdata_i) & `ITA_CMD_RW_MASK))
        else $error("control value not kept");

    // Control register reads back what was kept
    cmd_readback_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_read_s |=> reg_rdata_o == $past(st.cmd))
        else $error("control readback wrong");

    // Reserved control bits stay low
    cmd_reserved_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.cmd[15:13] == 3'b000)
        else $error("reserved control bits set");

    // Table and address hold between launches
    req_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !wr_cmd |=> tbl_req_o.addr == $past(tbl_req_o.addr) && tbl_req_o.table_sel == $past(tbl_req_o.table_sel))
        else $error("request fields moved");

    // Static, VLAN and all writes leave busy low
    fast_no_busy_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s ##0 !(reg_wdata_i[12] && reg_wdata_i[11]) |=> !st.busy)
        else $error("busy set for fast access");

    // Busy only while an answer is awaited
    busy_in_wait_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.busy |-> st.state == ita_pkg::ITA_ST_WAIT)
        else $error("busy outside wait");

    // Busy stays up until the answer
    busy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.busy && !tbl_rsp_i.valid && !wr_cmd |=> st.busy)
        else $error("busy fell early");

    // Busy follows the table choice, one check per table
    for (genvar t = 0; t < 4; t++) begin : g_tbl_busy
        tbl_busy_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
            read_cmd_s ##0 reg_wdata_i[11:10] == 2'(t) |=> st.busy == (t >= 2)) else $error("busy wrong for table");
    end

    // Answer loads the whole data word
    answer_load_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        answer_taken_s |=> st.data == $past(tbl_rsp_i.data))
        else $error("answer not loaded");

    // Answer with nothing outstanding is ignored
    answer_idle_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        st.state == ita_pkg::ITA_ST_IDLE && tbl_rsp_i.valid && !reg_wr_i |=> st.data == $past(st.data))
        else $error("stray answer loaded");

    // Top data bits refuse bus writes
    top_readonly_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        top_write_s |=> st.data[66:64] == $past(st.data[66:64]))
        else $error("top bits written");

    // Reserved top bits read zero
    top_reserved_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        top_read_s |=> reg_rdata_o[15:8] == 8'h00 && reg_rdata_o[6:3] == 4'h0)
        else $error("reserved top bits set");

    // Launch carries the top data bits as well
    req_top_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        cmd_write_s |=> tbl_req_o.data[66:64] == $past(st.data[66:64]))
        else $error("top bits not launched");

    // Read data is zero outside the answer cycle
    rdata_idle_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not cleared");

    // Word two reads back
    word_two_rd_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        w2_read_s |=> reg_rdata_o == $past(st.data[47:32]))
        else $error("word two readback wrong");

    // Word three reads back
    word_three_rd_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        w3_read_s |=> reg_rdata_o == $past(st.data[63:48]))
        else $error("word three readback wrong");

    // Word zero reads back
    word_zero_rd_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        w0_read_s |=> reg_rdata_o == $past(st.data[15:0]))
        else $error("word zero readback wrong");

    // Word one reads back
    word_one_rd_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        w1_read_s |=> reg_rdata_o == $past(st.data[31:16]))
        else $error("word one readback wrong");

    // Bank number reads back in any bank
    bank_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_rd_i && in_bsel |=> reg_rdata_o == {8'h00, $past(st.bank)})
        else $error("bank readback wrong");

    // Bank number moves only on its own write
    bank_hold_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        !(reg_wr_i && in_bsel) |=> st.bank == $past(st.bank))
        else $error("bank changed unasked");

    // Writes in other banks leave the data word alone
    foreign_write_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        foreign_write_s |=> st.data == $past(st.data))
        else $error("write leaked from other bank");

    // Reads in other banks return zero, bank select excepted
    foreign_read_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        foreign_read_s |=> reg_rdata_o == 16'h0000)
        else $error("read leaked from other bank");
endmodule : ita_indirect_table_access

// ---- verification/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    ita_pkg::ita_req_t tbl_req_o;
    ita_pkg::ita_rsp_t tbl_rsp_i = '0;
    int error_cnt = 0;
    int num_checks = 0;
    logic [15:0] d;
    logic [66:0] rdat = 67'h5_0123_4567_89ab_cdef;

    ita_indirect_table_access ita_indirect_table_access_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .tbl_req_o(tbl_req_o), .tbl_rsp_i(tbl_rsp_i));

    // Core clock, 25 ns period
    always #12.5 ref_clk_i = ~ref_clk_i;

    // Compare and count
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Bus write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr

    // Bus read, data taken in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask : rd

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    // Writes outside the indirect bank are ignored, reset words read zero
    task automatic t_reset;
        wr(4'h4, 16'hffff);
        wr(4'he, 16'h002a);
        rd(4'he, d); chk(d, 16'h002a);
        for (int i = 0; i < 12; i += 2) begin
            rd(i[3:0], d); chk(d, 16'h0000);
        end
        $display("test reset done");
    endtask : t_reset

    // Data words read back, top register refuses writes
    task automatic t_words;
        wr(4'h8, 16'h1100); wr(4'ha, 16'h3322); wr(4'h4, 16'h5544); wr(4'h6, 16'h7766);
        wr(4'h2, 16'hffff);
        rd(4'h8, d); chk(d, 16'h1100);
        rd(4'ha, d); chk(d, 16'h3322);
        rd(4'h4, d); chk(d, 16'h5544);
        rd(4'h6, d); chk(d, 16'h7766);
        rd(4'h2, d); chk(d, 16'h0000);
        $display("test words done");
    endtask : t_words

    // Control write launches a table write for every table
    task automatic t_twrite;
        logic [15:0] c;
        for (int s = 0; s < 4; s++) begin
            c = 16'(16'he000 | (s << 10) | (16'h0155 + s));
            wr(4'h0, c);
            chk(tbl_req_o.valid, 1'b1);
            chk(tbl_req_o.is_read, 1'b0);
            chk(tbl_req_o.table_sel, s[1:0]);
            chk(tbl_req_o.addr, c[9:0]);
            chk(tbl_req_o.data[63:0], 64'h7766_5544_3322_1100);
            rd(4'h0, d); chk(tbl_req_o.valid, 1'b0);
            chk(d, c & 16'h1fff);
        end
        $display("test table write done");
    endtask : t_twrite

    // Reads of every table, busy only for dynamic and counters
    task automatic t_tread;
        int n;
        for (int s = 0; s < 4; s++) begin
            wr(4'h0, 16'(16'h1000 | (s << 10) | 16'h0005));
            chk(tbl_req_o.is_read, 1'b1);
            rd(4'h2, d); chk(d[7], s >= 2);
            @(posedge ref_clk_i);
            tbl_rsp_i <= '{1'b1, rdat ^ s};
            @(posedge ref_clk_i);
            tbl_rsp_i.valid <= 1'b0;
            n = 0;
            do begin
                rd(4'h2, d); n++;
                if (n > 20) begin error_cnt++; wrap_up(); end
            end while (d[7] !== 1'b0);
            chk(d, 16'h0005);
            rd(4'h8, d); chk(d, rdat[15:0] ^ s);
        end
        $display("test table read done");
    endtask : t_tread

    // Reserved bank still switches banks
    task automatic t_bank43;
        wr(4'he, 16'h002b);
        rd(4'he, d); chk(d, 16'h002b);
        wr(4'h4, 16'h1234);
        rd(4'h4, d); chk(d, 16'h0000);
        wr(4'he, 16'h002a);
        rd(4'h4, d); chk(d, rdat[47:32]);
        $display("test bank43 done");
    endtask : t_bank43

    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_words();
        t_twrite();
        t_tread();
        t_bank43();
        wrap_up();
    end
endmodule : tb_top
